//--- epi_top.sv
// External pin interrupt unit: dedicated pins, pin-change groups, APB registers
// Notes on behaviour
// - Sources raise requests whatever the pin direction; pins are watched as inputs.
// - Group 2 toggles from inputs 23..16, 1 from 15..8, 0 from 7..0, 3 from 26..24.
// - Pin changes are seen from raw levels, usable as a wake signal without clock.
// - Sense field: 00 low level, 01 any change, 10 falling, 11 rising.
// - Low-level mode requests continuously while the pin stays low.
// - Edge and change detection runs on the sampled clock path.
// - Low-level wake is a plain combinational view of the pin.
// - Low level gone before start-up ends gives a wake but no request.
// - Pulses at least two sample periods long always make a request.
// - Dedicated request reaches core only with global and individual enable.
// - Bits 7..4 of enable, flag and group registers read zero.
// - Dedicated flag sets on edge or change, clears on handler entry or write one.
// - Dedicated flag is held clear while the pin is in low-level mode.
// - Group enable with global enable lets a group raise its own request.
// - Input joins its group only when its mask bit is set.
// - Group flag sets on enabled change, clears on handler entry or write one.
// - Pin-change input active only when mask and group enable are both set.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module epi_top #(
  parameter int num_ded = epi_pkg::epi_num_ded,
  parameter int num_pc = epi_pkg::epi_num_pc
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [num_ded-1:0] dedicated_irq_pins,
  input wire logic [num_pc-1:0] pin_change_inputs,
  input wire logic global_irq_enable,
  input wire logic [num_ded-1:0] ded_irq_ack,
  input wire logic [epi_pkg::epi_num_grp-1:0] grp_irq_ack,
  input wire logic startup_done,
  output logic [num_ded-1:0] ded_irq_req,
  output logic [epi_pkg::epi_num_grp-1:0] grp_irq_req,
  output logic wake_request
);
  localparam int ngrp = epi_pkg::epi_num_grp;

  initial begin
    if (num_ded != epi_pkg::epi_num_ded) $error("epi_top supports exactly four dedicated pins");
    if (num_pc != epi_pkg::epi_num_pc) $error("epi_top supports exactly 27 pin-change inputs");
    if (epi_pkg::epi_grp3_lo + epi_pkg::epi_grp3_width != num_pc) begin
      $error("epi_top pin-change groups must cover every input");
    end
    if (epi_pkg::epi_grp3_lo != (ngrp - 1) * epi_pkg::epi_grp_width) begin
      $error("epi_top last group must follow three full groups");
    end
    if (num_ded * epi_pkg::epi_sense_width > 8) begin
      $error("epi_top sense fields must fit one register byte");
    end
  end

  // Software registers
  logic [7:0] ext_irq_sense_control;
  logic [num_ded-1:0] ext_irq_enable_mask;
  logic [ngrp-1:0] pin_change_group_control;
  logic [7:0] pin_change_mask_group0;
  logic [7:0] pin_change_mask_group1;
  logic [7:0] pin_change_mask_group2;
  logic [epi_pkg::epi_grp3_width-1:0] pin_change_mask_group3;
  logic global_sw_enable;
  logic [num_ded-1:0] dedicated_irq_flag;
  logic [ngrp-1:0] pin_change_group_flags;

  // Bus decode
  logic wr_stb;
  logic [7:0] wbyte;
  logic hit;
  logic global_on;

  assign wr_stb = psel && penable && pwrite;
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;
  // Requests need both the core's global enable and the software copy
  assign global_on = global_irq_enable && global_sw_enable;

  always_comb begin
    if (paddr == epi_pkg::epi_off_sense) begin
      hit = 1'b1;
    end else if (paddr == epi_pkg::epi_off_enable) begin
      hit = 1'b1;
    end else if (paddr == epi_pkg::epi_off_flags) begin
      hit = 1'b1;
    end else if (paddr == epi_pkg::epi_off_grp_ctrl) begin
      hit = 1'b1;
    end else if (paddr == epi_pkg::epi_off_grp_flags) begin
      hit = 1'b1;
    end else if (paddr == epi_pkg::epi_off_mask0) begin
      hit = 1'b1;
    end else if (paddr == epi_pkg::epi_off_mask1) begin
      hit = 1'b1;
    end else if (paddr == epi_pkg::epi_off_mask2) begin
      hit = 1'b1;
    end else if (paddr == epi_pkg::epi_off_mask3) begin
      hit = 1'b1;
    end else if (paddr == epi_pkg::epi_off_status) begin
      hit = 1'b1;
    end else if (paddr == epi_pkg::epi_off_global) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // Unlisted or unaligned addresses are refused; writes to them change nothing
  assign pslverr = psel && penable && !hit;

  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_sense_control <= epi_pkg::epi_reset_byte;
      ext_irq_enable_mask <= '0;
      pin_change_group_control <= '0;
      pin_change_mask_group0 <= epi_pkg::epi_reset_byte;
      pin_change_mask_group1 <= epi_pkg::epi_reset_byte;
      pin_change_mask_group2 <= epi_pkg::epi_reset_byte;
      pin_change_mask_group3 <= '0;
      global_sw_enable <= 1'b0;
    end else if (wr_stb) begin
      if (paddr == epi_pkg::epi_off_sense) begin
        ext_irq_sense_control <= wbyte;
      end else if (paddr == epi_pkg::epi_off_enable) begin
        ext_irq_enable_mask <= wbyte[num_ded-1:0];
      end else if (paddr == epi_pkg::epi_off_grp_ctrl) begin
        pin_change_group_control <= wbyte[ngrp-1:0];
      end else if (paddr == epi_pkg::epi_off_mask0) begin
        pin_change_mask_group0 <= wbyte;
      end else if (paddr == epi_pkg::epi_off_mask1) begin
        pin_change_mask_group1 <= wbyte;
      end else if (paddr == epi_pkg::epi_off_mask2) begin
        pin_change_mask_group2 <= wbyte;
      end else if (paddr == epi_pkg::epi_off_mask3) begin
        pin_change_mask_group3 <= wbyte[epi_pkg::epi_grp3_width-1:0];
      end else if (paddr == epi_pkg::epi_off_global) begin
        global_sw_enable <= wbyte[0];
      end
    end
  end

  // Pin sampling; pin direction is not seen here so outputs still trigger
  logic [num_ded-1:0] ded_level;
  logic [num_ded-1:0] ded_changed;
  logic [num_pc-1:0] pc_level;
  logic [num_pc-1:0] pc_changed;

  epi_sync #(.width(num_ded)) u_ded_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(dedicated_irq_pins),
    .level(ded_level),
    .changed(ded_changed)
  );

  epi_sync #(.width(num_pc)) u_pc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(pin_change_inputs),
    .level(pc_level),
    .changed(pc_changed)
  );

  // Filtered levels start low, so pins idling high show one change after reset;
  // every source is masked or in low-level mode then, so no flag is set.
  // A pulse must span two samples to pass the filter; a shorter one may be lost.
  // Dedicated pins: sense decode and flags
  logic [num_ded-1:0] ded_event;
  logic [num_ded-1:0] ded_low_mode;
  logic [num_ded-1:0] ded_low_active;
  logic [num_ded-1:0] ded_flag_wclr;
  logic [1:0] sense [num_ded];
  logic ded_flag_wr;

  assign ded_flag_wr = wr_stb && (paddr == epi_pkg::epi_off_flags);

  always_comb begin
    for (int i = 0; i < num_ded; i++) begin
      // Sense field of pin n sits at bits 2n+1 and 2n
      sense[i] = ext_irq_sense_control[i*epi_pkg::epi_sense_width +: epi_pkg::epi_sense_width];
      ded_low_mode[i] = (sense[i] == epi_pkg::epi_sense_low);
      ded_low_active[i] = ded_low_mode[i] && !ded_level[i];
      case (sense[i])
        epi_pkg::epi_sense_any: ded_event[i] = ded_changed[i];
        epi_pkg::epi_sense_fall: ded_event[i] = ded_changed[i] && ded_level[i];
        epi_pkg::epi_sense_rise: ded_event[i] = ded_changed[i] && !ded_level[i];
        default: ded_event[i] = 1'b0;
      endcase
      ded_flag_wclr[i] = ded_flag_wr && wbyte[i];
    end
  end

  // Pin-change groups
  logic [num_pc-1:0] pc_mask;
  logic [num_pc-1:0] pc_group_en;
  logic [num_pc-1:0] pc_armed;
  logic [num_pc-1:0] pc_raw_diff;
  logic [ngrp-1:0] grp_event;
  logic [ngrp-1:0] grp_flag_wclr;
  logic [ngrp-1:0] grp_raw_change;
  logic grp_flag_wr;

  assign pc_mask = {pin_change_mask_group3, pin_change_mask_group2,
                    pin_change_mask_group1, pin_change_mask_group0};
  assign grp_flag_wr = wr_stb && (paddr == epi_pkg::epi_off_grp_flags);

  // Membership follows the input number: eight inputs a group, three in the last
  always_comb begin
    for (int j = 0; j < num_pc; j++) begin
      pc_group_en[j] = pin_change_group_control[j / epi_pkg::epi_grp_width];
    end
  end

  // Input counts only with mask and group enable both set
  assign pc_armed = pc_mask & pc_group_en;
  // Raw pin against the filtered level: seen before any clock edge samples it
  assign pc_raw_diff = pin_change_inputs ^ pc_level;

  always_comb begin
    for (int g = 0; g < ngrp; g++) begin
      grp_event[g] = 1'b0;
      grp_raw_change[g] = 1'b0;
      grp_flag_wclr[g] = grp_flag_wr && wbyte[g];
    end
    for (int j = 0; j < num_pc; j++) begin
      if (pc_armed[j] && pc_changed[j]) begin
        grp_event[j / epi_pkg::epi_grp_width] = 1'b1;
      end
      if (pc_armed[j] && pc_raw_diff[j]) begin
        grp_raw_change[j / epi_pkg::epi_grp_width] = 1'b1;
      end
    end
  end

  // A set in the same cycle as a clear wins, so no event is lost to handler entry
  genvar k;
  generate
    for (k = 0; k < num_ded; k++) begin : g_ded
      epi_flag u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set(ded_event[k]),
        .clear(ded_irq_ack[k] || ded_flag_wclr[k]),
        .hold_clear(ded_low_mode[k]),
        .flag(dedicated_irq_flag[k])
      );
    end
    for (k = 0; k < ngrp; k++) begin : g_grp
      epi_flag u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set(grp_event[k]),
        .clear(grp_irq_ack[k] || grp_flag_wclr[k]),
        .hold_clear(1'b0),
        .flag(pin_change_group_flags[k])
      );
    end
  endgenerate

  // Low level is only honoured once start-up has completed
  logic [num_ded-1:0] low_req;
  assign low_req = ded_low_active & {num_ded{startup_done}};

  // Request lines to the core
  always_comb begin
    for (int i = 0; i < num_ded; i++) begin
      ded_irq_req[i] = global_on && ext_irq_enable_mask[i] &&
                       (dedicated_irq_flag[i] || low_req[i]);
    end
  end

  // Group requests leave through each group's own line
  always_comb begin
    for (int g = 0; g < ngrp; g++) begin
      grp_irq_req[g] = global_on && pin_change_group_control[g] &&
                       pin_change_group_flags[g];
    end
  end

  // Wake paths that need no sampled clock edge
  logic low_wake;
  always_comb begin
    low_wake = 1'b0;
    for (int i = 0; i < num_ded; i++) begin
      if (ext_irq_enable_mask[i] && ded_low_mode[i] && !dedicated_irq_pins[i]) begin
        low_wake = 1'b1;
      end
    end
  end
  assign wake_request = low_wake || (|grp_raw_change);

  // Read data, registered on the setup cycle
  // Unused upper bits read zero; status shows the filtered dedicated pin levels
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = '0;
    if (paddr == epi_pkg::epi_off_sense) begin
      next_prdata[7:0] = ext_irq_sense_control;
    end else if (paddr == epi_pkg::epi_off_enable) begin
      next_prdata[num_ded-1:0] = ext_irq_enable_mask;
    end else if (paddr == epi_pkg::epi_off_flags) begin
      next_prdata[num_ded-1:0] = dedicated_irq_flag;
    end else if (paddr == epi_pkg::epi_off_grp_ctrl) begin
      next_prdata[ngrp-1:0] = pin_change_group_control;
    end else if (paddr == epi_pkg::epi_off_grp_flags) begin
      next_prdata[ngrp-1:0] = pin_change_group_flags;
    end else if (paddr == epi_pkg::epi_off_mask0) begin
      next_prdata[7:0] = pin_change_mask_group0;
    end else if (paddr == epi_pkg::epi_off_mask1) begin
      next_prdata[7:0] = pin_change_mask_group1;
    end else if (paddr == epi_pkg::epi_off_mask2) begin
      next_prdata[7:0] = pin_change_mask_group2;
    end else if (paddr == epi_pkg::epi_off_mask3) begin
      next_prdata[epi_pkg::epi_grp3_width-1:0] = pin_change_mask_group3;
    end else if (paddr == epi_pkg::epi_off_status) begin
      next_prdata[num_ded-1:0] = ded_level;
    end else if (paddr == epi_pkg::epi_off_global) begin
      next_prdata[0] = global_sw_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule

//--- epi_pkg.sv
// Register map, field layout and sense encodings of the external pin interrupt unit
package epi_pkg;
  localparam logic [11:0] epi_off_sense = 12'h000;
  localparam logic [11:0] epi_off_enable = 12'h004;
  localparam logic [11:0] epi_off_flags = 12'h008;
  localparam logic [11:0] epi_off_grp_ctrl = 12'h00c;
  localparam logic [11:0] epi_off_grp_flags = 12'h010;
  localparam logic [11:0] epi_off_mask0 = 12'h014;
  localparam logic [11:0] epi_off_mask1 = 12'h018;
  localparam logic [11:0] epi_off_mask2 = 12'h01c;
  localparam logic [11:0] epi_off_mask3 = 12'h020;
  localparam logic [11:0] epi_off_status = 12'h024;
  localparam logic [11:0] epi_off_global = 12'h028;
  localparam logic [7:0] epi_reset_byte = 8'h00;
  localparam int epi_num_ded = 4;
  localparam int epi_num_pc = 27;
  localparam int epi_num_grp = 4;
  localparam int epi_grp_width = 8;
  localparam int epi_grp3_lo = 24;
  localparam int epi_grp3_width = 3;
  localparam int epi_sense_width = 2;
  localparam logic [1:0] epi_sense_low = 2'h0;
  localparam logic [1:0] epi_sense_any = 2'h1;
  localparam logic [1:0] epi_sense_fall = 2'h2;
  localparam logic [1:0] epi_sense_rise = 2'h3;
endpackage

//--- epi_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module epi_sync #(
  parameter int width = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [width-1:0] pin,
  output logic [width-1:0] level,
  output logic [width-1:0] changed
);
  logic [width-1:0] stage1;
  logic [width-1:0] stage2;
  logic [width-1:0] stage3;

  initial begin
    if (width < 1) $error("epi_sync width must be positive");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Output follows only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '0;
    end else begin
      for (int i = 0; i < width; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < width; i++) begin
      changed[i] = (stage2[i] == stage3[i]) && (stage3[i] != level[i]);
    end
  end
endmodule

//--- epi_flag.sv
// Sticky interrupt flag: set beats clear
`timescale 1ns/10ps
module epi_flag (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set,
  input wire logic clear,
  input wire logic hold_clear,
  output logic flag
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (hold_clear) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule

//--- epi_props.sv
// Concurrent checks on the ports of the external pin interrupt unit
`timescale 1ns/10ps
module epi_props #(
  parameter int num_ded = 4,
  parameter int num_pc = 27
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [num_ded-1:0] dedicated_irq_pins,
  input wire logic [num_pc-1:0] pin_change_inputs,
  input wire logic global_irq_enable,
  input wire logic [num_ded-1:0] ded_irq_ack,
  input wire logic [3:0] grp_irq_ack,
  input wire logic startup_done,
  input wire logic [num_ded-1:0] ded_irq_req,
  input wire logic [3:0] grp_irq_req
);
  logic [num_ded+num_pc-1:0] prev_pins;
  logic [3:0] quiet;
  wire logic is_wr = psel && penable && pwrite;
  wire logic is_rd = psel && penable && !pwrite;
  wire logic unmapped = (paddr > 12'h028) || (paddr[1:0] != 2'h0);
  // Cycles since any pin last moved, so sync latency cannot cause false firing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_pins <= '0;
    end else begin
      prev_pins <= {dedicated_irq_pins, pin_change_inputs};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= 4'h0;
    end else if ({dedicated_irq_pins, pin_change_inputs} != prev_pins) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_calm;
    quiet >= 4'ha && !$past(is_wr) && $stable(global_irq_enable);
  endsequence
  sequence s_grp_acked;
    quiet >= 4'ha && (grp_irq_ack & grp_irq_req) != 4'h0;
  endsequence
  chk_pready_high: assert property (pready)
    else $error("pready low");
  chk_unmapped_err: assert property (psel && penable && unmapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (!(psel && penable && unmapped) |-> !pslverr)
    else $error("pslverr outside unmapped access");
  chk_reserved_zero: assert property (is_rd && paddr inside {12'h004, 12'h008, 12'h00c, 12'h010}
      |-> prdata[31:4] == 28'h0)
    else $error("unused bits read nonzero");
  chk_upper_zero: assert property (is_rd |-> prdata[31:8] == 24'h0)
    else $error("upper read bits nonzero");
  chk_gie_gates: assert property (!global_irq_enable |-> ded_irq_req == '0 && grp_irq_req == 4'h0)
    else $error("request without global enable");
  chk_ded_steady: assert property (s_calm ##0 ($stable(startup_done) && $past(ded_irq_ack) == '0)
      |-> $stable(ded_irq_req))
    else $error("dedicated request moved without cause");
  chk_grp_steady: assert property (s_calm ##0 ($past(grp_irq_ack) == 4'h0) |-> $stable(grp_irq_req))
    else $error("group request moved without cause");
  chk_ack_clears: assert property (s_grp_acked |=> (grp_irq_req & $past(grp_irq_ack)) == 4'h0)
    else $error("handler entry did not clear group flag");
endmodule

//--- epi_core_model.sv
// Core side: enters a handler for the lowest pending dedicated request, else the lowest group request, after a delay
`timescale 1ns/10ps
module epi_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic auto_ack,
  input wire logic slow,
  input wire logic [3:0] ded_irq_req,
  input wire logic [3:0] grp_irq_req,
  output logic [3:0] ded_irq_ack,
  output logic [3:0] grp_irq_ack
);
  logic [3:0] wait_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      ded_irq_ack <= 4'h0;
      grp_irq_ack <= 4'h0;
    end else begin
      ded_irq_ack <= 4'h0;
      grp_irq_ack <= 4'h0;
      if (!auto_ack || (ded_irq_req | grp_irq_req | ded_irq_ack | grp_irq_ack) == 4'h0 ||
          (ded_irq_ack | grp_irq_ack) != 4'h0) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt < (slow ? 4'h8 : 4'h1)) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else begin
        wait_cnt <= 4'h0;
        if (ded_irq_req != 4'h0) begin
          ded_irq_ack <= ded_irq_req & (~ded_irq_req + 4'h1);
        end else begin
          grp_irq_ack <= grp_irq_req & (~grp_irq_req + 4'h1);
        end
      end
    end
  end
endmodule

//--- epi_top_test.sv
// Self-checking bench for the external pin interrupt unit
`timescale 1ns/10ps
module epi_top_test;
  logic pclk, presetn, psel, penable, pwrite, gie, startup_done, auto_ack, slow, pready, pslverr;
  logic wake_request, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] ded_pins, ded_req, grp_req, ded_ack, grp_ack;
  logic [26:0] pc_pins;
  int n_fail = 0;
  int n_checks = 0;
  epi_top u_epi_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dedicated_irq_pins(ded_pins), .pin_change_inputs(pc_pins),
    .global_irq_enable(gie), .ded_irq_ack(ded_ack), .grp_irq_ack(grp_ack),
    .startup_done(startup_done), .ded_irq_req(ded_req), .grp_irq_req(grp_req),
    .wake_request(wake_request));
  epi_core_model u_epi_core_model (.pclk(pclk), .presetn(presetn), .auto_ack(auto_ack),
    .slow(slow), .ded_irq_req(ded_req), .grp_irq_req(grp_req), .ded_irq_ack(ded_ack),
    .grp_irq_ack(grp_ack));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(what, exp, rd);
    check("slave error", {31'h0, a > 12'h028}, {31'h0, err});
  endtask
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, gie, auto_ack, slow} = 7'h0;
    {paddr, pwdata, pc_pins} = '0;
    ded_pins = 4'hf;
    startup_done = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i <= 11; i++) begin
      rd_chk("reset value", 12'(i * 4),
             (12'(i * 4) == epi_pkg::epi_off_status) ? 32'h0f : 32'h0);
    end
    wr(epi_pkg::epi_off_enable, 32'hff);
    rd_chk("enable unused bits", epi_pkg::epi_off_enable, 32'h0f);
    wr(epi_pkg::epi_off_grp_ctrl, 32'hff);
    rd_chk("group ctrl unused bits", epi_pkg::epi_off_grp_ctrl, 32'h0f);
    wr(epi_pkg::epi_off_grp_ctrl, 32'h0);
    wr(epi_pkg::epi_off_enable, 32'h0);
    $display("test registers done");
    gie <= 1'b1;
    wr(epi_pkg::epi_off_global, 32'h1);
    wr(epi_pkg::epi_off_sense, 32'he4);
    rd_chk("sense readback", epi_pkg::epi_off_sense, 32'he4);
    wr(epi_pkg::epi_off_enable, 32'h0e);
    ded_pins <= 4'h1;
    idle(10);
    rd_chk("flags after fall", epi_pkg::epi_off_flags, 32'h06);
    check("requests after fall", 32'h6, {28'h0, ded_req});
    ded_pins <= 4'hf;
    idle(10);
    rd_chk("flags after rise", epi_pkg::epi_off_flags, 32'h0e);
    wr(epi_pkg::epi_off_flags, 32'h02);
    rd_chk("flags after write one", epi_pkg::epi_off_flags, 32'h0c);
    gie <= 1'b0;
    idle(2);
    check("requests global off", 32'h0, {28'h0, ded_req});
    gie <= 1'b1;
    wr(epi_pkg::epi_off_enable, 32'h04);
    check("requests masked", 32'h4, {28'h0, ded_req});
    wr(epi_pkg::epi_off_enable, 32'h0c);
    auto_ack <= 1'b1;
    slow <= 1'b1;
    idle(30);
    rd_chk("flags after handler", epi_pkg::epi_off_flags, 32'h0);
    $display("test edge modes done");
    wr(epi_pkg::epi_off_enable, 32'h01);
    ded_pins <= 4'he;
    idle(30);
    check("low level request", 32'h1, {28'h0, ded_req});
    rd_chk("low level flag", epi_pkg::epi_off_flags, 32'h0);
    startup_done <= 1'b0;
    idle(2);
    check("request before start-up", 32'h0, {28'h0, ded_req});
    check("wake from low level", 32'h1, {31'h0, wake_request});
    startup_done <= 1'b1;
    ded_pins <= 4'hf;
    idle(10);
    check("low level released", 32'h0, {28'h0, ded_req});
    auto_ack <= 1'b0;
    $display("test low level done");
    wr(epi_pkg::epi_off_grp_ctrl, 32'h0f);
    for (int g = 0; g < 4; g++) wr(12'(epi_pkg::epi_off_mask0 + 4 * g), 32'h01);
    for (int g = 0; g < 4; g++) begin
      pc_pins[g * 8 + 1] <= 1'b1;
      idle(10);
      rd_chk("unmasked input", epi_pkg::epi_off_grp_flags, 32'h0);
      pc_pins[g * 8] <= 1'b1;
      idle(1);
      check("pin change wake", 32'h1, {31'h0, wake_request});
      idle(1);
      pc_pins[g * 8] <= 1'b0;
      idle(10);
      rd_chk("group flag", epi_pkg::epi_off_grp_flags, 32'h1 << g);
      check("group request", 32'h1 << g, {28'h0, grp_req});
      wr(epi_pkg::epi_off_grp_flags, 32'h1 << g);
      rd_chk("group flag write one", epi_pkg::epi_off_grp_flags, 32'h0);
    end
    wr(epi_pkg::epi_off_grp_ctrl, 32'h0e);
    pc_pins[0] <= 1'b1;
    idle(10);
    check("group disabled", 32'h0, {28'h0, grp_req});
    rd_chk("group disabled flag", epi_pkg::epi_off_grp_flags, 32'h0);
    auto_ack <= 1'b1;
    wr(epi_pkg::epi_off_grp_ctrl, 32'h0f);
    pc_pins[8] <= 1'b1;
    idle(40);
    rd_chk("group flags after handler", epi_pkg::epi_off_grp_flags, 32'h0);
    $display("test pin change groups done");
    close_out();
  end
endmodule
bind epi_top epi_props #(.num_ded(num_ded), .num_pc(num_pc)) u_epi_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .dedicated_irq_pins(dedicated_irq_pins),
  .pin_change_inputs(pin_change_inputs), .global_irq_enable(global_irq_enable),
  .ded_irq_ack(ded_irq_ack), .grp_irq_ack(grp_irq_ack), .startup_done(startup_done),
  .ded_irq_req(ded_irq_req), .grp_irq_req(grp_irq_req));
